// file: logic/sdp_cmd_decode.sv
// Combinational decode of one command into pin code, masks and selects.
// Assumes the controller registers every result before it reaches a pin.
`include "sdp_map.svh"
module sdp_cmd_decode (
    // Command channel
    sdp_cmd_if.dec cif
);
    import sdp_pkg::*;

    function automatic sdp_pins_s sdp_code(input sdp_cmd_e c);
        unique case (c)
            SDP_NOP: sdp_code = `SDP_CODE_NOP;
            SDP_ACT: sdp_code = `SDP_CODE_ACT;
            SDP_RD: sdp_code = `SDP_CODE_RD;
            SDP_WR: sdp_code = `SDP_CODE_WR;
            SDP_PRE: sdp_code = `SDP_CODE_PRE;
            SDP_REF: sdp_code = `SDP_CODE_REF;
            SDP_MRS: sdp_code = `SDP_CODE_MRS;
            default: sdp_code = `SDP_CODE_NOP;
        endcase
    endfunction : sdp_code

    logic odd_word;
    logic [1:0] bank_idx;

    assign cif.pins = sdp_code(cif.cmd);

    assign cif.in_space =
        (cif.addr[`SDP_SPACE_HI:`SDP_SPACE_LO] == `SDP_SPACE_CODE) &&
        (cif.addr[`SDP_RSV_HI:`SDP_RSV_LO] == 2'h0);
    assign bank_idx = cif.addr[`SDP_BANK_HI:`SDP_BANK_LO];

    genvar g;
    generate
        for (g = 0; g < `SDP_BANK_NUM; g++) begin : g_bank
            assign cif.bank_sel_n[g] =
                !(cif.in_space && (cif.cmd != SDP_NOP) &&
                  (bank_idx == 2'(g)));
        end
    endgenerate

    assign odd_word = cif.addr[`SDP_ODD_BIT];
    // masks only on writes; reads and other commands keep them low
    assign cif.low_mask = (cif.cmd == SDP_WR) && !cif.bus32 && odd_word;
    // even single word or 32-bit bus
    assign cif.high_mask = (cif.cmd == SDP_WR) &&
        (cif.bus32 || (cif.single && !odd_word));
endmodule : sdp_cmd_decode

// file: logic/sdp_cmd_if.sv
// Carries one command from the controller to its decoder and back.
// Assumes both ends run in the same clock domain; all paths are comb.
interface sdp_cmd_if;
    import sdp_pkg::*;
    sdp_cmd_e cmd;
    logic [31:0] addr;
    logic bus32;
    logic single;
    sdp_pins_s pins;
    logic low_mask;
    logic high_mask;
    logic [3:0] bank_sel_n;
    logic in_space;

    modport src (output cmd, output addr, output bus32, output single,
        input pins, input low_mask, input high_mask, input bank_sel_n,
        input in_space);
    modport dec (input cmd, input addr, input bus32, input single,
        output pins, output low_mask, output high_mask, output bank_sel_n,
        output in_space);
endinterface : sdp_cmd_if

// file: logic/sdp_ctrl.sv
// SDRAM port command pin controller: registers decoded commands onto the
// pins, handles self refresh, suspend and hand-over of the bus to a host.
// Assumes one clock, synchronous inputs and external pull resistors.
//
// Overview of operation
// - Bank selects go low for commands to SDRAM space, reserved excluded.
// - Only the current bus owner drives bank selects; others float them.
// - Row strobe low marks row address; otherwise part of command code.
// - Column strobe low marks column address; otherwise part of command.
// - Write strobe low on writes, high on reads while column strobe low.
// - Data masks matter only with column strobe; inactive on reads.
// - Odd word write on 64-bit bus raises the low-word mask.
// - Even single word or 32-bit bus write raises the high-word mask.
// - Address bit 10 leaves on its own pin, apart from shared address.
// - Clock enable drives self refresh and suspend entry and exit.
// - Before granting the host, enter self refresh; pins float as the grant goes low.
`include "sdp_map.svh"
module sdp_ctrl (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    // Command request
    input wire logic cmd_valid,
    input wire sdp_pkg::sdp_cmd_e cmd,
    input wire logic [31:0] cmd_addr,
    input wire logic cmd_single,
    output logic cmd_ready,
    // Configuration and arbitration
    input wire logic bus32,
    input wire logic bus_owner,
    input wire logic power_down_req,
    input wire logic host_bus_request,
    // Host grant pin
    output logic host_bus_grant_n,
    output logic host_bus_grant_oe,
    // SDRAM pins and their enables
    output logic [3:0] sdram_bank_selects_n,
    output logic ras_n,
    output logic cas_n,
    output logic memory_write_strobe_n,
    output logic low_word_data_mask,
    output logic high_word_data_mask,
    output logic dedicated_address_bit10_pin,
    output logic memory_clock_enable,
    output logic ctl_oe,
    output logic cke_oe
);
    import sdp_pkg::*;

    sdp_cmd_if cif ();
    sdp_cmd_decode sdp_cmd_decode_inst (
        .cif(cif)
    );

    sdp_state_e st_q, st_d;
    logic ready_q, take, enter_sr;
    logic [3:0] bsel_q;
    sdp_pins_s pins_q;
    logic lmask_q, hmask_q, a10_q, cke_q, oe_q, ckeoe_q, grant_q, goe_q;

    // Host waits for an owner that is idle, then self refresh goes first
    assign enter_sr = (st_q == SDP_IDLE) && bus_owner && host_bus_request;
    assign take = cmd_valid && ready_q && bus_owner && !host_bus_request &&
        !power_down_req;

    assign cif.cmd = enter_sr ? SDP_REF : (take ? cmd : SDP_NOP);
    assign cif.addr = cmd_addr;
    assign cif.bus32 = bus32;
    assign cif.single = cmd_single;

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            SDP_IDLE: begin
                if (enter_sr) begin
                    st_d = SDP_SREF;
                end else if (bus_owner && power_down_req) begin
                    st_d = SDP_SUSP;
                end
            end
            SDP_SREF: st_d = SDP_HOST;
            SDP_HOST: begin
                if (!host_bus_request) begin
                    st_d = SDP_WAKE;
                end
            end
            SDP_WAKE: st_d = SDP_IDLE;
            SDP_SUSP: begin
                if (!power_down_req || host_bus_request) begin
                    st_d = SDP_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_q <= SDP_IDLE;
            ready_q <= 1'h0;
        end else if (ce) begin
            st_q <= st_d;
            ready_q <= (st_d == SDP_IDLE);
        end
    end

    // Command pins: one cycle per accepted command or self refresh entry, NOP otherwise
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pins_q <= `SDP_CODE_NOP;
            bsel_q <= `SDP_BANK_IDLE;
            lmask_q <= 1'h0;
            hmask_q <= 1'h0;
            a10_q <= 1'h0;
        end else if (ce) begin
            pins_q <= cif.pins;
            // all banks enter self refresh together
            bsel_q <= enter_sr ? 4'h0 : cif.bank_sel_n;
            lmask_q <= cif.low_mask;
            hmask_q <= cif.high_mask;
            a10_q <= take && cmd_addr[`SDP_A10_BIT];
        end
    end

    // clock enable low in self refresh and suspend
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cke_q <= `SDP_CKE_RESET;
        end else if (ce) begin
            cke_q <= (st_d == SDP_IDLE);
        end
    end

    // Drive enables; a slave never fights the owner on shared pins
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            oe_q <= 1'h0;
            ckeoe_q <= 1'h0;
            grant_q <= 1'h1;
            goe_q <= 1'h0;
        end else if (ce) begin
            // float while not owner or host holds bus
            oe_q <= bus_owner && (st_d != SDP_HOST);
            ckeoe_q <= bus_owner && (st_d != SDP_HOST);
            // grant only after self refresh entry
            grant_q <= !(st_d == SDP_HOST);
            goe_q <= bus_owner;
        end
    end

    assign cmd_ready = ready_q;
    assign host_bus_grant_n = grant_q;
    assign host_bus_grant_oe = goe_q;
    assign sdram_bank_selects_n = bsel_q;
    assign ras_n = pins_q.ras_n;
    assign cas_n = pins_q.cas_n;
    assign memory_write_strobe_n = pins_q.we_n;
    assign low_word_data_mask = lmask_q;
    assign high_word_data_mask = hmask_q;
    assign dedicated_address_bit10_pin = a10_q;
    assign memory_clock_enable = cke_q;
    assign ctl_oe = oe_q;
    assign cke_oe = ckeoe_q;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    sequence s_host_asked;
        ce && enter_sr;
    endsequence
    sequence s_sref_code;
        !ras_n && !cas_n && memory_write_strobe_n && !memory_clock_enable;
    endsequence

    a_bank_space: assert property (
        ce && take && !cif.in_space |=> sdram_bank_selects_n == 4'hF)
        else $error("bank select outside SDRAM space");
    a_slave_float: assert property (
        ce && !bus_owner |=> !ctl_oe && !cke_oe && !host_bus_grant_oe)
        else $error("non-owner drives SDRAM pins");
    a_read_code: assert property (
        ce && take && cmd == SDP_RD |=> ras_n && !cas_n &&
        memory_write_strobe_n && !low_word_data_mask && !high_word_data_mask)
        else $error("read command code or masks wrong");
    a_write_strobe: assert property (
        ce && take && cmd == SDP_WR |=> !cas_n && !memory_write_strobe_n)
        else $error("write strobe not low with column strobe");
    a_mask_cas: assert property (
        (low_word_data_mask || high_word_data_mask) |-> !cas_n)
        else $error("data mask raised without column strobe");
    a_low_mask: assert property (
        ce && take && cmd == SDP_WR && !bus32 && cmd_addr[0]
        |=> low_word_data_mask && !high_word_data_mask)
        else $error("odd word mask wrong");
    a_high_mask: assert property (
        ce && take && cmd == SDP_WR && bus32 |=> high_word_data_mask)
        else $error("32-bit bus high mask not raised");
    a_a10_pin: assert property (
        ce && take |=> dedicated_address_bit10_pin == $past(cmd_addr[10]))
        else $error("bit 10 pin does not follow address");
    // The float step only follows if the self refresh cycle was enabled
    a_host_hand: assert property (
        s_host_asked |=> s_sref_code ##1 (!$past(ce) or (!ctl_oe &&
        !cke_oe && !host_bus_grant_n)))
        else $error("self refresh or float missing before grant");
    a_act_code: assert property (
        ce && take && cmd == SDP_ACT |=> !ras_n && cas_n &&
        memory_write_strobe_n)
        else $error("activate code wrong");
    a_suspend_cke: assert property (
        ce && st_q == SDP_IDLE && bus_owner && power_down_req &&
        !host_bus_request |=> !memory_clock_enable)
        else $error("clock enable not low on suspend");
    a_pre_code: assert property (
        ce && take && cmd == SDP_PRE |=> !ras_n && cas_n &&
        !memory_write_strobe_n)
        else $error("precharge code wrong");
    a_even_mask: assert property (
        ce && take && cmd == SDP_WR && !bus32 && cmd_single &&
        !cmd_addr[0] |=> high_word_data_mask && !low_word_data_mask)
        else $error("even single word mask wrong");
endmodule : sdp_ctrl

// file: logic/sdp_map.svh
// Pin codes, address fields and decode constants of the SDRAM port.
// Assumes inclusion by the design modules and by the test bench only.
`ifndef SDP_MAP_SVH
`define SDP_MAP_SVH

// Address space decode: top two bits select SDRAM space
`define SDP_SPACE_HI 31
`define SDP_SPACE_LO 30
`define SDP_SPACE_CODE 2'h1
// Bits that must be zero inside SDRAM space; other values are reserved
`define SDP_RSV_HI 29
`define SDP_RSV_LO 28
// Bank select field of the address
`define SDP_BANK_HI 27
`define SDP_BANK_LO 26
`define SDP_BANK_NUM 4
// Address bit copied to the dedicated bit-10 pin
`define SDP_A10_BIT 10
// Word address bit that marks an odd word
`define SDP_ODD_BIT 0

// Standard command codes on {ras_n, cas_n, we_n}
`define SDP_CODE_NOP 3'h7
`define SDP_CODE_ACT 3'h3
`define SDP_CODE_RD 3'h5
`define SDP_CODE_WR 3'h4
`define SDP_CODE_PRE 3'h2
`define SDP_CODE_REF 3'h1
`define SDP_CODE_MRS 3'h0

// Reset values of the pin registers
`define SDP_BANK_IDLE 4'hF
`define SDP_CKE_RESET 1'h1
`endif

// file: logic/sdp_pkg.sv
// Types shared by the SDRAM port command logic.
// Assumes nothing beyond the map header.
package sdp_pkg;
    typedef enum logic [2:0] {
        SDP_NOP = 3'h0,
        SDP_ACT = 3'h1,
        SDP_RD = 3'h2,
        SDP_WR = 3'h3,
        SDP_PRE = 3'h4,
        SDP_REF = 3'h5,
        SDP_MRS = 3'h6
    } sdp_cmd_e;

    // Gray along idle -> self refresh -> host -> wake -> idle
    typedef enum logic [2:0] {
        SDP_IDLE = 3'h0,
        SDP_SREF = 3'h1,
        SDP_HOST = 3'h3,
        SDP_WAKE = 3'h2,
        SDP_SUSP = 3'h4
    } sdp_state_e;

    typedef struct packed {
        logic ras_n;
        logic cas_n;
        logic we_n;
    } sdp_pins_s;
endpackage : sdp_pkg

// file: test/sdp_ctrl_tb_top.sv
// Self-checking bench for the SDRAM command pin controller.
// Assumes the design files and sdp_map.svh are reachable.
`include "sdp_map.svh"
module sdp_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import sdp_pkg::*;
    logic mclk, rst_n, ce, cmd_valid, cmd_single, bus32, bus_owner;
    logic power_down_req, host_bus_request, cmd_ready, grant_n, grant_oe;
    sdp_cmd_e cmd;
    logic [31:0] cmd_addr;
    logic [3:0] sel_n, sel_w;
    logic ras_n, cas_n, we_n, lmask, hmask, a10, cke, ctl_oe, cke_oe;
    logic ras_w, cas_w, we_w, cke_w, grant_w, in_sref;
    logic [7:0] n_wr;
    int n_mismatch, check_count, cyc;
    // Released pins fall to pull-ups; clock enable is pulled down
    assign sel_w = ctl_oe ? sel_n : 4'hF;
    assign ras_w = ctl_oe ? ras_n : 1'h1;
    assign cas_w = ctl_oe ? cas_n : 1'h1;
    assign we_w = ctl_oe ? we_n : 1'h1;
    assign cke_w = cke_oe ? cke : 1'h0;
    assign grant_w = grant_oe ? grant_n : 1'h1;

    sdp_ctrl sdp_ctrl_inst (.mclk(mclk), .rst_n(rst_n), .ce(ce),
        .cmd_valid(cmd_valid), .cmd(cmd), .cmd_addr(cmd_addr),
        .cmd_single(cmd_single), .cmd_ready(cmd_ready), .bus32(bus32),
        .bus_owner(bus_owner), .power_down_req(power_down_req),
        .host_bus_request(host_bus_request), .host_bus_grant_n(grant_n),
        .host_bus_grant_oe(grant_oe), .sdram_bank_selects_n(sel_n),
        .ras_n(ras_n), .cas_n(cas_n), .memory_write_strobe_n(we_n),
        .low_word_data_mask(lmask), .high_word_data_mask(hmask),
        .dedicated_address_bit10_pin(a10), .memory_clock_enable(cke),
        .ctl_oe(ctl_oe), .cke_oe(cke_oe));
    sdp_mem_model sdp_mem_model_inst (.mclk(mclk), .sel_n(sel_w),
        .ras_n(ras_w), .cas_n(cas_w), .we_n(we_w), .cke(cke_w),
        .in_sref(in_sref), .n_wr(n_wr));

    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
            n_mismatch++;
        end
    endtask : chk

    task results;
        if (n_mismatch == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    task t_cmd(input sdp_cmd_e c, input logic [2:0] code,
        input logic [31:0] a, input logic b32, input logic s);
        logic [3:0] sel;
        logic lm, hm;
        sel = (a[31:30] == 2'h1 && a[29:28] == 2'h0) ?
            ~(4'h1 << a[27:26]) : 4'hF;
        lm = c == SDP_WR && !b32 && a[0];
        hm = c == SDP_WR && (b32 || (s && !a[0]));
        @(posedge mclk);
        cmd_valid <= 1'h1;
        cmd <= c;
        cmd_addr <= a;
        bus32 <= b32;
        cmd_single <= s;
        @(posedge mclk);
        cmd_valid <= 1'h0;
        #1;
        chk({sel_w, ras_w, cas_w, we_w}, {sel, code});
        chk({lmask, hmask, a10}, {lm, hm, a[10]});
        @(posedge mclk);
        #1;
        chk({sel_w, ras_w, cas_w, we_w}, 7'h7F);
    endtask : t_cmd

    // Control pins and the grant float while another party owns the bus
    task t_owner;
        @(posedge mclk);
        bus_owner <= 1'h0;
        cmd_valid <= 1'h1;
        cmd <= SDP_WR;
        cmd_addr <= 32'h4000_0000;
        repeat (2) @(posedge mclk);
        #1;
        chk({ctl_oe, grant_oe, sel_w, ras_w, cas_w, we_w}, 9'h07F);
        @(posedge mclk);
        cmd_valid <= 1'h0;
        bus_owner <= 1'h1;
        repeat (2) @(posedge mclk);
        #1;
        chk(ctl_oe, 1'h1);
    endtask : t_owner

    task t_host;
        @(posedge mclk);
        host_bus_request <= 1'h1;
        @(posedge mclk);
        #1;
        chk({sel_w, ras_w, cas_w, we_w, cke_w, cmd_ready}, 9'h004);
        @(posedge mclk);
        #1;
        chk({ctl_oe, cke_oe, grant_w, grant_oe, ras_w, cke_w, in_sref},
            7'h0D);
        repeat (3) @(posedge mclk);
        host_bus_request <= 1'h0;
        @(posedge mclk);
        #1;
        chk({grant_w, ctl_oe, cke_w}, 3'h6);
        @(posedge mclk);
        #1;
        chk({cke_w, cmd_ready}, 2'h3);
        // The memory leaves self refresh once it samples the enable high
        @(posedge mclk);
        #1;
        chk(in_sref, 1'h0);
    endtask : t_host

    task t_susp;
        @(posedge mclk);
        power_down_req <= 1'h1;
        cmd_valid <= 1'h1;
        cmd <= SDP_ACT;
        cmd_addr <= 32'h4000_0000;
        repeat (2) @(posedge mclk);
        #1;
        chk({cke_w, ras_w, cas_w, we_w}, 4'h7);
        @(posedge mclk);
        power_down_req <= 1'h0;
        cmd_valid <= 1'h0;
        @(posedge mclk);
        #1;
        chk(cke_w, 1'h1);
    endtask : t_susp

    initial begin
        mclk = 1'h0;
        forever #50 mclk = ~mclk;
    end

    // Run is about 60 cycles; the ceiling leaves ample margin
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_mismatch++;
            results;
        end
    end

    initial begin
        {rst_n, cmd_valid, cmd_single, bus32, power_down_req} = 5'h00;
        {ce, bus_owner, host_bus_request} = 3'h6;
        cmd = SDP_NOP;
        cmd_addr = 32'h0000_0000;
        repeat (2) @(posedge mclk);
        rst_n <= 1'h1;
        #1;
        chk({sel_n, ras_n, cas_n, we_n, cke, ctl_oe, grant_n, grant_oe,
            cmd_ready}, 12'hFF4);
        for (int i = 0; i < 20 && cmd_ready !== 1'h1; i++) @(posedge mclk);
        repeat (2) @(posedge mclk);
        t_cmd(SDP_WR, `SDP_CODE_WR, 32'h4000_0001, 1'h0, 1'h0);
        t_cmd(SDP_WR, `SDP_CODE_WR, 32'h4400_0400, 1'h0, 1'h1);
        t_cmd(SDP_WR, `SDP_CODE_WR, 32'h4800_0002, 1'h1, 1'h0);
        t_cmd(SDP_WR, `SDP_CODE_WR, 32'h4C00_0001, 1'h1, 1'h0);
        t_cmd(SDP_RD, `SDP_CODE_RD, 32'h4000_0001, 1'h0, 1'h1);
        t_cmd(SDP_ACT, `SDP_CODE_ACT, 32'h4400_0400, 1'h0, 1'h0);
        t_cmd(SDP_PRE, `SDP_CODE_PRE, 32'h4000_0400, 1'h0, 1'h0);
        t_cmd(SDP_REF, `SDP_CODE_REF, 32'h4800_0000, 1'h0, 1'h0);
        t_cmd(SDP_MRS, `SDP_CODE_MRS, 32'h4C00_0020, 1'h0, 1'h0);
        t_cmd(SDP_WR, `SDP_CODE_WR, 32'h5000_0000, 1'h0, 1'h0);
        t_cmd(SDP_WR, `SDP_CODE_WR, 32'h8000_0001, 1'h0, 1'h0);
        chk(n_wr, 8'h04);
        t_owner;
        t_host;
        t_susp;
        results;
    end
endmodule : sdp_ctrl_tb_top

// file: test/sdp_mem_model.sv
// Behavioural SDRAM watching its command pins after pull resistors.
// Assumes the bench resolves released pins to their pulled levels.
module sdp_mem_model (
    // Clock
    input wire logic mclk,
    // Resolved command pins
    input wire logic [3:0] sel_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic cke,
    // Observed state
    output logic in_sref,
    output logic [7:0] n_wr
);
    timeunit 1ns;
    timeprecision 1ns;
    logic cke_q;
    logic [2:0] code;
    assign code = {ras_n, cas_n, we_n};
    initial begin
        in_sref = 1'h0;
        n_wr = 8'h00;
        cke_q = 1'h1;
    end
    // A command counts only if the previous edge saw the clock enabled
    always @(posedge mclk) begin
        cke_q <= cke;
        if (cke_q && !cke && sel_n != 4'hF && code == 3'h1) begin
            in_sref <= 1'h1;
        end else if (cke) begin
            in_sref <= 1'h0;
        end
        if (cke_q && cke && sel_n != 4'hF && code == 3'h4) begin
            n_wr <= n_wr + 8'h01;
        end
    end
endmodule : sdp_mem_model
